// File: hw/decoder_defs.svh
// register offsets, field positions and reset values of the decoder
`ifndef DECODER_DEFS_SVH
`define DECODER_DEFS_SVH

`define OFS_INSTR 6'h00
`define OFS_INDEX 6'h04
`define OFS_ACCUM 6'h08
`define OFS_STACK_CC 6'h0C
`define OFS_CC 6'h10
`define OFS_STATUS 6'h14
`define OFS_RESULT 6'h18

// condition_code_register bit positions
`define CC_H 4
`define CC_I 3
`define CC_N 2
`define CC_Z 1
`define CC_C 0

// interrupt mask set at reset, others clear
`define CC_RESET 5'h08
`define ACCUM_IRQ_BIT 16
`define STATUS_BRANCH_BIT 8

`endif

// File: hw/decoder_pkg.sv
// types shared by the opcode and flag decoder
package decoder_pkg;

  // instruction group picked from the opcode high nibble
  typedef enum logic [5:0] {
    GRP_BIT_TEST = 6'h01,
    GRP_BIT_SET = 6'h02,
    GRP_BRANCH = 6'h04,
    GRP_RMW = 6'h08,
    GRP_CONTROL = 6'h10,
    GRP_REG_MEM = 6'h20
  } group_e;

endpackage

// File: hw/byte_adder.sv
// eight-bit adder that reports the carry out of the low nibble
`timescale 1ns/10ps
`default_nettype none

module byte_adder #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] a,
  input wire logic [WIDTH-1:0] b,
  input wire logic cin,
  output logic [WIDTH-1:0] sum,
  output logic half_carry,
  output logic carry
);

  logic [4:0] low;
  logic [WIDTH:0] full;

  // low nibble summed apart so the bit 3 to bit 4 carry is visible
  assign low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  assign full = {1'b0, a} + {1'b0, b} + {{WIDTH{1'b0}}, cin};
  assign half_carry = low[4];
  assign sum = full[WIDTH-1:0];
  assign carry = full[WIDTH];

endmodule
`default_nettype wire

// File: hw/cpu_opcode_flag_decoder.sv
// opcode decode and condition-code update, reached over wishbone
`timescale 1ns/10ps
`default_nettype none
`include "decoder_defs.svh"

module cpu_opcode_flag_decoder #(
  parameter int AW = 8
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [4:0] cc_flags,
  output logic branch_taken,
  output logic [15:0] effective_addr
);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [23:0] instr_r;
  logic [7:0] index_r;
  logic [16:0] accum_r;
  logic [4:0] stack_cc_r;
  logic [4:0] condition_code_register_r;
  logic [4:0] cc_nxt;
  logic [7:0] result_r;
  logic [7:0] result_nxt;
  logic [15:0] ea_r;
  logic [15:0] ea_nxt;
  logic branch_r;
  logic branch_nxt;
  decoder_pkg::group_e group_r;
  decoder_pkg::group_e group_nxt;
  logic exec_r;
  logic ack_r;
  logic [31:0] rdata;
  logic [31:0] wmask;
  logic wr_stb;

  wire [7:0] opcode = instr_r[7:0];
  wire [7:0] op1 = instr_r[15:8];
  wire [7:0] op2 = instr_r[23:16];
  wire [3:0] hi = opcode[7:4];
  wire [3:0] lo = opcode[3:0];
  wire [7:0] acc = accum_r[7:0];
  wire [7:0] mem = accum_r[15:8];
  wire irq_level = accum_r[`ACCUM_IRQ_BIT];
  wire [5:0] word_adr = wb_adr_i[7:2];

  // ------------------------------------------------------------
  // wishbone slave
  // ------------------------------------------------------------
  // one wait state: ack rises the cycle after the strobe, drops next
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
    end
  end
  assign wb_ack_o = ack_r;
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;

  // byte enables widened to a bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{wb_sel_i[i]}};
    end
  end

  // read mux; unmapped offsets answer with zero
  always_comb begin
    rdata = 32'h0000_0000;
    unique case ({word_adr, 2'b00})
      {2'b00, `OFS_INSTR}: rdata = {8'h00, instr_r};
      {2'b00, `OFS_INDEX}: rdata = {24'h00_0000, index_r};
      {2'b00, `OFS_ACCUM}: rdata = {15'h0000, accum_r};
      {2'b00, `OFS_STACK_CC}: rdata = {27'h000_0000, stack_cc_r};
      {2'b00, `OFS_CC}: rdata = {27'h000_0000, condition_code_register_r};
      {2'b00, `OFS_STATUS}: rdata = {23'h00_0000, branch_r, 2'b00, group_r};
      {2'b00, `OFS_RESULT}: rdata = {ea_r, 8'h00, result_r};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // read data held in flops, taken when the access is acknowledged
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r) begin
      wb_dat_o <= rdata;
    end
  end

  // operand registers written by software
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      instr_r <= 24'h00_0000;
      index_r <= 8'h00;
      accum_r <= 17'h0_0000;
      stack_cc_r <= 5'h00;
    end else if (wr_stb) begin
      if ({word_adr, 2'b00} == {2'b00, `OFS_INSTR}) begin
        instr_r <= (instr_r & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0]);
      end
      if ({word_adr, 2'b00} == {2'b00, `OFS_INDEX} && wb_sel_i[0]) begin
        index_r <= wb_dat_i[7:0];
      end
      if ({word_adr, 2'b00} == {2'b00, `OFS_ACCUM}) begin
        accum_r <= (accum_r & ~wmask[16:0]) | (wb_dat_i[16:0] & wmask[16:0]);
      end
      if ({word_adr, 2'b00} == {2'b00, `OFS_STACK_CC} &&
          wb_sel_i[0]) begin
        stack_cc_r <= wb_dat_i[4:0];
      end
    end
  end

  // a write of the instruction word runs one decode on the next edge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      exec_r <= 1'b0;
    end else begin
      exec_r <= wr_stb && ({word_adr, 2'b00} == {2'b00, `OFS_INSTR});
    end
  end

  // ------------------------------------------------------------
  // arithmetic
  // ------------------------------------------------------------
  logic [7:0] add_a;
  logic [7:0] add_b;
  logic add_cin;
  logic [7:0] add_sum;
  logic add_h;
  logic add_c;
  logic is_sub;

  // subtract is a plus not-b plus one; borrow is the inverted carry
  always_comb begin
    is_sub = (lo == 4'h0) || (lo == 4'h1) || (lo == 4'h2) || (lo == 4'h3);
    add_a = (lo == 4'h3) ? index_r : acc;
    add_b = is_sub ? ~mem : mem;
    if (is_sub) begin
      add_cin = !(lo == 4'h2 && condition_code_register_r[`CC_C]);
    end else begin
      add_cin = (lo == 4'h9) && condition_code_register_r[`CC_C];
    end
  end

  byte_adder #(
    .WIDTH(8)
  ) u_adder (
    .a(add_a),
    .b(add_b),
    .cin(add_cin),
    .sum(add_sum),
    .half_carry(add_h),
    .carry(add_c)
  );

  // ------------------------------------------------------------
  // decode and flag update
  // ------------------------------------------------------------
  logic [7:0] v;
  logic cond;
  logic nz_upd;
  logic tbit;

  // group from high nibble, then per-group flags and address
  always_comb begin
    cc_nxt = condition_code_register_r;
    result_nxt = result_r;
    ea_nxt = ea_r;
    branch_nxt = 1'b0;
    group_nxt = decoder_pkg::GRP_REG_MEM;
    v = 8'h00;
    cond = 1'b0;
    nz_upd = 1'b0;
    tbit = mem[opcode[3:1]];
    unique case (hi)
      4'h0: group_nxt = decoder_pkg::GRP_BIT_TEST;
      4'h1: group_nxt = decoder_pkg::GRP_BIT_SET;
      4'h2: group_nxt = decoder_pkg::GRP_BRANCH;
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7: group_nxt = decoder_pkg::GRP_RMW;
      4'h8, 4'h9: group_nxt = decoder_pkg::GRP_CONTROL;
      default: group_nxt = decoder_pkg::GRP_REG_MEM;
    endcase
    unique case (group_nxt)
      decoder_pkg::GRP_BIT_TEST: begin
        // even opcode branches on set bit, odd on clear bit
        ea_nxt = {8'h00, op1};
        cc_nxt[`CC_C] = tbit;
        branch_nxt = (tbit == !opcode[0]);
        result_nxt = op2;
      end
      decoder_pkg::GRP_BIT_SET: begin
        // no flags move on a bit set or clear
        ea_nxt = {8'h00, op1};
        result_nxt = mem;
        result_nxt[opcode[3:1]] = !opcode[0];
      end
      decoder_pkg::GRP_BRANCH: begin
        unique case (lo[3:1])
          3'h0: cond = 1'b1;
          3'h1: cond = !(condition_code_register_r[`CC_C] ||
                         condition_code_register_r[`CC_Z]);
          3'h2: cond = !condition_code_register_r[`CC_C];
          3'h3: cond = !condition_code_register_r[`CC_Z];
          3'h4: cond = !condition_code_register_r[`CC_H];
          3'h5: cond = !condition_code_register_r[`CC_N];
          3'h6: cond = !condition_code_register_r[`CC_I];
          default: cond = !irq_level;
        endcase
        branch_nxt = cond ^ lo[0];
        result_nxt = op1;
      end
      decoder_pkg::GRP_RMW: begin
        // operand: accumulator, index or memory byte by addressing mode
        v = (hi == 4'h4) ? acc : (hi == 4'h5) ? index_r : mem;
        ea_nxt = (hi == 4'h6) ? {8'h00, index_r} + {8'h00, op1} :
                 (hi == 4'h7) ? {8'h00, index_r} : {8'h00, op1};
        nz_upd = 1'b1;
        unique case (lo)
          4'h0: begin
            result_nxt = 8'h00 - v;
            cc_nxt[`CC_C] = (v != 8'h00);
          end
          4'h3: begin
            result_nxt = ~v;
            cc_nxt[`CC_C] = 1'b1;
          end
          4'h4: begin
            result_nxt = {1'b0, v[7:1]};
            cc_nxt[`CC_C] = v[0];
          end
          4'h6: begin
            result_nxt = {condition_code_register_r[`CC_C], v[7:1]};
            cc_nxt[`CC_C] = v[0];
          end
          4'h7: begin
            result_nxt = {v[7], v[7:1]};
            cc_nxt[`CC_C] = v[0];
          end
          4'h8: begin
            result_nxt = {v[6:0], 1'b0};
            cc_nxt[`CC_C] = v[7];
          end
          4'h9: begin
            result_nxt = {v[6:0], condition_code_register_r[`CC_C]};
            cc_nxt[`CC_C] = v[7];
          end
          4'hA: result_nxt = v - 8'h01;
          4'hC: result_nxt = v + 8'h01;
          4'hD: result_nxt = v;
          4'hF: result_nxt = 8'h00;
          default: nz_upd = 1'b0; // unused slot, flags and result unchanged
        endcase
      end
      decoder_pkg::GRP_CONTROL: begin
        unique case (opcode)
          8'h80: cc_nxt = stack_cc_r;
          8'h83: cc_nxt[`CC_I] = 1'b1;
          8'h98: cc_nxt[`CC_C] = 1'b0;
          8'h99: cc_nxt[`CC_C] = 1'b1;
          8'h9A: cc_nxt[`CC_I] = 1'b0;
          8'h9B: cc_nxt[`CC_I] = 1'b1;
          8'h97: result_nxt = acc;
          8'h9F: result_nxt = index_r;
          default: result_nxt = result_r; // flags unaffected
        endcase
      end
      default: begin
        // register/memory: address by mode, then operation by low nibble
        unique case (hi)
          4'hA: ea_nxt = 16'h0000;
          4'hB: ea_nxt = {8'h00, op1};
          4'hC: ea_nxt = {op1, op2};
          4'hD: ea_nxt = {8'h00, index_r} + {op1, op2};
          4'hE: ea_nxt = {8'h00, index_r} + {8'h00, op1};
          default: ea_nxt = {8'h00, index_r};
        endcase
        nz_upd = 1'b1;
        unique case (lo)
          4'h0, 4'h1, 4'h2, 4'h3: begin
            result_nxt = add_sum;
            cc_nxt[`CC_C] = !add_c;
          end
          4'h9, 4'hB: begin
            result_nxt = add_sum;
            cc_nxt[`CC_C] = add_c;
            cc_nxt[`CC_H] = add_h;
          end
          4'h4, 4'h5: result_nxt = acc & mem;
          4'h6, 4'hE: result_nxt = mem;
          4'h7: result_nxt = acc;
          4'h8: result_nxt = acc ^ mem;
          4'hA: result_nxt = acc | mem;
          4'hF: result_nxt = index_r;
          default: nz_upd = 1'b0; // jumps leave flags alone
        endcase
      end
    endcase
    // negative and zero follow the result when the op tests them
    if (nz_upd) begin
      cc_nxt[`CC_N] = result_nxt[7];
      cc_nxt[`CC_Z] = (result_nxt == 8'h00);
    end
  end

  // software may load the flags; a decode in the same edge wins
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      condition_code_register_r <= `CC_RESET;
    end else if (exec_r) begin
      condition_code_register_r <= cc_nxt;
    end else if (wr_stb && wb_sel_i[0] &&
                 {word_adr, 2'b00} == {2'b00, `OFS_CC}) begin
      condition_code_register_r <= wb_dat_i[4:0];
    end
  end

  // decode outputs captured once per executed instruction
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      result_r <= 8'h00;
      ea_r <= 16'h0000;
      branch_r <= 1'b0;
      group_r <= decoder_pkg::GRP_BIT_TEST;
    end else if (exec_r) begin
      result_r <= result_nxt;
      ea_r <= ea_nxt;
      branch_r <= branch_nxt;
      group_r <= group_nxt;
    end
  end

  assign cc_flags = condition_code_register_r;
  assign branch_taken = branch_r;
  assign effective_addr = ea_r;

endmodule
`default_nettype wire

// File: sim/cpu_opcode_flag_decoder_properties.sv
// port-level checks for the opcode and flag decoder
`timescale 1ns/10ps
`default_nettype none
module decoder_checker #(
  parameter int AW = 8
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [4:0] cc_flags,
  input wire logic branch_taken,
  input wire logic [15:0] effective_addr
);
  logic [7:0] index_sh_r;
  logic [4:0] stack_sh_r;
  logic wr_ack;
  logic ins;
  assign wr_ack = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign ins = wr_ack && wb_adr_i[7:2] == 6'h00;
  // shadows of software writes, so decode results can be predicted
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      index_sh_r <= 8'h00;
      stack_sh_r <= 5'h00;
    end else if (wr_ack && wb_sel_i[0]) begin
      if (wb_adr_i[7:2] == 6'h01) index_sh_r <= wb_dat_i[7:0];
      if (wb_adr_i[7:2] == 6'h03) stack_sh_r <= wb_dat_i[4:0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_ack_follows;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("no ack");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_dat_hold;
    !$stable(wb_dat_o) |-> $past(wb_cyc_i && wb_stb_i && !wb_we_i);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("dat moved");
  property p_flags_cause;
    !$stable(cc_flags) |-> $past(wb_cyc_i && wb_we_i, 2);
  endproperty
  a_flags_cause: assert property (p_flags_cause)
    else $error("cc moved");
  property p_ix1;
    ins && wb_dat_i[7:4] == 4'hE |=> ##1 effective_addr ==
      {8'h00, index_sh_r} + {8'h00, $past(wb_dat_i[15:8], 2)};
  endproperty
  a_ix1: assert property (p_ix1) else $error("byte offset ea");
  property p_ix2;
    ins && wb_dat_i[7:4] == 4'hD |=> ##1 effective_addr ==
      {8'h00, index_sh_r} +
      {$past(wb_dat_i[15:8], 2), $past(wb_dat_i[23:16], 2)};
  endproperty
  a_ix2: assert property (p_ix2) else $error("word offset ea");
  property p_restore;
    ins && wb_dat_i[7:0] == 8'h80 |=> ##1 cc_flags == stack_sh_r;
  endproperty
  a_restore: assert property (p_restore)
    else $error("cc not restored");
  property p_bit_test;
    ins && wb_dat_i[7:4] == 4'h0 |=> ##1
      cc_flags[4:1] == $past(cc_flags[4:1], 2) &&
      branch_taken == (cc_flags[0] ^ $past(wb_dat_i[0], 2));
  endproperty
  a_bit_test: assert property (p_bit_test) else $error("bit test");
  property p_bit_set;
    ins && wb_dat_i[7:4] == 4'h1 |=> ##1 cc_flags == $past(cc_flags, 2) &&
      effective_addr == {8'h00, $past(wb_dat_i[15:8], 2)};
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set");
endmodule
`default_nettype wire

// File: sim/cpu_opcode_flag_decoder_test.sv
// self-checking bench for the opcode and flag decoder
`timescale 1ns/10ps
`default_nettype none
module cpu_opcode_flag_decoder_test;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] q;
  logic wb_ack_o;
  logic branch_taken;
  logic [4:0] cc_flags;
  logic [15:0] effective_addr;
  int mismatches = 0;
  int n_compared = 0;
  int a, b, s, n, cc, c;
  logic [31:0] e;
  cpu_opcode_flag_decoder #(.AW(8)) i_dut (.core_clk(core_clk),
    .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cc_flags(cc_flags), .branch_taken(branch_taken),
    .effective_addr(effective_addr));
  always #5 core_clk = ~core_clk;
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle; ack and read data are taken at the rising edge,
  // before that edge's updates, and the request is released right after
  task bus(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do begin
      @(posedge core_clk);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    chk(wb_ack_o, 1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // decode results land one cycle after the ack cycle
  task run(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
    bus(1'b1, 8'h00, {8'h00, b2, b1, op});
    @(posedge core_clk);
    @(negedge core_clk);
  endtask
  initial begin
    #200000;
    mismatches++;
    print_verdict;
  end
  initial begin
    a = $urandom(77);
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    #1;
    chk(cc_flags, 5'h08);
    bus(1'b0, 8'h10, 32'h0);
    chk(q, 32'h08);
    bus(1'b0, 8'h1C, 32'h0);
    chk(q, 32'h0);
    // every high nibble once, group read back from status
    for (n = 0; n < 16; n++) begin
      run({n[3:0], 4'hD}, 8'h00, 8'h00);
      bus(1'b0, 8'h14, 32'h0);
      e = n < 3 ? 1 << n : n < 8 ? 8 : n < 10 ? 16 : 32;
      chk(q[5:0], e);
    end
    // add and subtract family; the operand byte sits in the memory field
    repeat (24) begin
      a = $urandom % 256;
      b = $urandom % 256;
      cc = $urandom % 32;
      n = $urandom % 6;
      if (n == 4) n = 9;
      if (n == 5) n = 11;
      bus(1'b1, 8'h08, a + b * 256);
      bus(1'b1, 8'h04, 255 - a);
      bus(1'b1, 8'h10, cc);
      run({4'hA, n[3:0]}, 8'h00, 8'h00);
      c = (n == 2 || n == 9) ? cc % 2 : 0;
      if (n < 4) begin
        s = ((n == 3) ? 255 - a : a) - b - c;
        e = {cc[4:3], s[7], s[7:0] == 8'h00, s < 0};
      end else begin
        s = a + b + c;
        e = {a % 16 + b % 16 + c > 15, cc[3], s[7], s[7:0] == 8'h00, s > 255};
      end
      chk(cc_flags, e);
      bus(1'b0, 8'h18, 32'h0);
      chk(q[7:0], s[7:0]);
    end
    repeat (4) begin
      a = $urandom % 256;
      b = $urandom % 256;
      n = $urandom % 256;
      bus(1'b1, 8'h04, a);
      run(8'hE6, b[7:0], 8'h00);
      chk(effective_addr, a + b);
      run(8'hD6, b[7:0], n[7:0]);
      chk(effective_addr, (a + b * 256 + n) % 65536);
    end
    repeat (3) begin
      cc = $urandom % 32;
      bus(1'b1, 8'h0C, cc);
      run(8'h80, 8'h00, 8'h00);
      chk(cc_flags, cc);
    end
    // each bit in both senses, other flags random
    for (n = 0; n < 16; n++) begin
      a = $urandom % 256;
      cc = $urandom % 32;
      bus(1'b1, 8'h08, a << 8);
      bus(1'b1, 8'h10, cc);
      run(n[7:0], 8'h40, 8'h12);
      chk(cc_flags, {cc[4:1], a[n / 2]});
      chk(branch_taken, a[n / 2] ^ n[0]);
    end
    // relative branches: every condition in both senses
    for (n = 0; n < 16; n++) begin
      a = $urandom % 131072;
      cc = $urandom % 32;
      bus(1'b1, 8'h08, a);
      bus(1'b1, 8'h10, cc);
      run({4'h2, n[3:0]}, 8'h33, 8'h00);
      case (n / 2)
        0: e = 1;
        1: e = !(cc[0] || cc[1]);
        2: e = !cc[0];
        3: e = !cc[1];
        4: e = !cc[4];
        5: e = !cc[2];
        6: e = !cc[3];
        default: e = !a[16];
      endcase
      chk(branch_taken, e ^ n[0]);
      chk(cc_flags, cc);
    end
    // read-modify-write ops, each in one random operand mode, against a model
    for (n = 0; n < 16; n++) begin
      a = $urandom % 256;
      b = 3 + $urandom % 5;
      cc = $urandom % 32;
      bus(1'b1, 8'h08, a * 257);
      bus(1'b1, 8'h04, a);
      bus(1'b1, 8'h10, cc);
      run({b[3:0], n[3:0]}, 8'h21, 8'h00);
      c = cc % 2;
      case (n)
        0: s = (256 - a) % 256;
        3: s = 255 - a;
        4: s = a / 2;
        6: s = c * 128 + a / 2;
        7: s = (a / 128) * 128 + a / 2;
        8: s = (a * 2) % 256;
        9: s = (a * 2) % 256 + c;
        10: s = (a + 255) % 256;
        12: s = (a + 1) % 256;
        13: s = a;
        15: s = 0;
        default: s = -1;
      endcase
      if (n == 0) c = (a != 0);
      if (n == 3) c = 1;
      if (n == 4 || n == 6 || n == 7) c = a % 2;
      if (n == 8 || n == 9) c = a / 128;
      e = cc;
      if (s >= 0) e = {cc[4:3], s[7], s == 0, c[0]};
      chk(cc_flags, e);
      if (b == 6) chk(effective_addr, a + 33);
      if (s >= 0) begin
        bus(1'b0, 8'h18, 32'h0);
        chk(q[7:0], s);
      end
    end
    // control ops: carry and mask moves, transfers, no-ops, interrupt
    for (n = 0; n < 17; n++) begin
      a = $urandom % 256;
      b = $urandom % 256;
      cc = $urandom % 32;
      bus(1'b1, 8'h08, a);
      bus(1'b1, 8'h04, b);
      bus(1'b1, 8'h10, cc);
      run(n == 16 ? 8'h83 : {4'h9, n[3:0]}, 8'h00, 8'h00);
      e = cc;
      if (n == 8) e[0] = 1'b0;
      if (n == 9) e[0] = 1'b1;
      if (n == 10) e[3] = 1'b0;
      if (n == 11 || n == 16) e[3] = 1'b1;
      chk(cc_flags, e);
      bus(1'b0, 8'h18, 32'h0);
      if (n == 7) chk(q[7:0], a);
      if (n == 15) chk(q[7:0], b);
    end
    // reset again mid-run: outputs and status back to reset values
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(negedge core_clk);
    chk(cc_flags, 5'h08);
    chk(effective_addr, 16'h0000);
    chk(branch_taken, 1'b0);
    bus(1'b0, 8'h14, 32'h0);
    chk(q, 32'h01);
    // a flag write without its byte enable must leave the flags alone
    wb_sel_i <= 4'hE;
    bus(1'b1, 8'h10, 32'h0000_001F);
    wb_sel_i <= 4'hF;
    @(negedge core_clk);
    chk(cc_flags, 5'h08);
    print_verdict;
  end
endmodule
bind cpu_opcode_flag_decoder decoder_checker #(.AW(AW)) i_chk (
  .core_clk(core_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .cc_flags(cc_flags), .branch_taken(branch_taken),
  .effective_addr(effective_addr));
`default_nettype wire
